// ===== logic/touch_threshold_slider_accel.sv
`timescale 1ns/100ps
`include "touch_defines.svh"
// What this block does
// - delta above noise but not touch threshold is a spike, flagged in o_noise_spike
// - noise fraction codes give 6.25, 12.5, 25 or 50 percent of threshold
// - first noise register holds channels 1 to 4, two bits each
// - second noise register holds channels 5 to 7 and the group field
// - delta above lid threshold sets that channel's lid status bit
// - lid fraction codes give 6.25, 12.5, 25 or 50 percent of threshold
// - lid fields packed four per register, last holds channels 13 and 14
// - enable bit allows extra interrupts after accelerated slides, else none
// - limit field caps extra interrupts, graded by half and three quarters
// - window field picks 350 to 980 ms; slower slides give none
// - speed is slider sensors touched in 100 ms, scaled by 2-bit field
// - scaled repeat intervals by sensor count and scale code
// - short base rate makes code 11 use fixed 140, 105, 70 ms
// - repeat intervals counted in measurement cycles
// - touch when delta exceeds the channel threshold
// - lid event when all pattern bits are set in lid status
module touch_threshold_slider_accel
  import touch_pkg::*;
#(
  parameter int DELTA_W = 8,
  parameter int MS_TICK_CYCLES = `CLK_KHZ,
  parameter int SPEED_WINDOW_MS = `SPEED_WINDOW_MS
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic [48:0] i_button_thresh,
  input wire logic [6:0] i_group_thresh,
  input wire logic [14*DELTA_W-1:0] i_delta,
  input wire logic i_sample_valid,
  input wire logic [13:0] i_lid_pattern,
  input wire logic [3:0] i_slider_base_repeat_rate,
  output logic [13:0] o_touch,
  output logic [13:0] o_noise_spike,
  output logic [13:0] o_lid_status,
  output logic o_lid_event,
  output logic [2:0] o_speed_count,
  output logic o_irq
);
  // --------------------------------------------------
  // configuration registers
  // --------------------------------------------------
  logic [7:0] noise_fraction_ch1_4;
  logic [7:0] noise_fraction_ch5_7_group;
  logic [7:0] lid_fraction_ch1_4;
  logic [7:0] lid_fraction_ch5_8;
  logic [7:0] lid_fraction_ch9_12;
  logic [7:0] lid_fraction_ch13_14;
  logic [7:0] slide_speed_config;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      noise_fraction_ch1_4 <= `RST_NOISE;
      noise_fraction_ch5_7_group <= `RST_NOISE;
      lid_fraction_ch1_4 <= `RST_LID;
      lid_fraction_ch5_8 <= `RST_LID;
      lid_fraction_ch9_12 <= `RST_LID;
      lid_fraction_ch13_14 <= `RST_LID_LAST;
      slide_speed_config <= `RST_SLIDE_CFG;
    end else if (i_en && i_reg_wr) begin
      case (i_reg_addr)
        `OFS_NOISE_CH1_4: noise_fraction_ch1_4 <= i_reg_wdata;
        `OFS_NOISE_CH5_7_GRP: noise_fraction_ch5_7_group <= i_reg_wdata;
        `OFS_LID_CH1_4: lid_fraction_ch1_4 <= i_reg_wdata;
        `OFS_LID_CH5_8: lid_fraction_ch5_8 <= i_reg_wdata;
        `OFS_LID_CH9_12: lid_fraction_ch9_12 <= i_reg_wdata;
        `OFS_LID_CH13_14: lid_fraction_ch13_14 <= i_reg_wdata & `LID_LAST_MASK;
        `OFS_SLIDE_CFG: slide_speed_config <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_en && i_reg_rd) begin
      case (i_reg_addr)
        `OFS_NOISE_CH1_4: o_reg_rdata <= noise_fraction_ch1_4;
        `OFS_NOISE_CH5_7_GRP: o_reg_rdata <= noise_fraction_ch5_7_group;
        `OFS_LID_CH1_4: o_reg_rdata <= lid_fraction_ch1_4;
        `OFS_LID_CH5_8: o_reg_rdata <= lid_fraction_ch5_8;
        `OFS_LID_CH9_12: o_reg_rdata <= lid_fraction_ch9_12;
        `OFS_LID_CH13_14: o_reg_rdata <= lid_fraction_ch13_14;
        `OFS_SLIDE_CFG: o_reg_rdata <= slide_speed_config;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  logic accel_extra_irq_enable;
  logic [2:0] max_extra;
  logic [1:0] slide_window_code;
  logic [1:0] speed_repeat_scale;
  assign accel_extra_irq_enable = slide_speed_config[`ACCEL_EN_BIT];
  assign max_extra = slide_speed_config[`MAX_INT_LSB +: 3];
  assign slide_window_code = slide_speed_config[`SLIDE_TIME_LSB +: 2];
  assign speed_repeat_scale = slide_speed_config[`SCALE_LSB +: 2];

  // --------------------------------------------------
  // per channel qualification
  // --------------------------------------------------
  logic [27:0] lid_fields;
  logic [13:0] touch_now;
  logic [13:0] noise_now;
  logic [13:0] lid_now;
  assign lid_fields = {lid_fraction_ch13_14[3:0], lid_fraction_ch9_12,
                       lid_fraction_ch5_8, lid_fraction_ch1_4};

  genvar ch;
  generate
    for (ch = 0; ch < 14; ch++) begin : g_ch
      logic [6:0] thresh;
      logic [1:0] channel_noise_fraction;
      // split per register so no branch elaborates a select outside its register
      if (ch < 4) begin : g_button
        assign thresh = i_button_thresh[ch*7 +: 7];
        assign channel_noise_fraction = noise_fraction_ch1_4[ch*2 +: 2];
      end else if (ch < 7) begin : g_button_hi
        assign thresh = i_button_thresh[ch*7 +: 7];
        assign channel_noise_fraction = noise_fraction_ch5_7_group[(ch-4)*2 +: 2];
      end else begin : g_group
        // every grouped sensor shares one threshold and one noise field
        assign thresh = i_group_thresh;
        assign channel_noise_fraction = noise_fraction_ch5_7_group[7:6];
      end
      channel_qualify #(
        .DELTA_W(DELTA_W)
      ) u_qual (
        .i_thresh(thresh),
        .i_noise_frac(channel_noise_fraction),
        .i_lid_frac(lid_fields[ch*2 +: 2]),
        .i_delta(i_delta[ch*DELTA_W +: DELTA_W]),
        .o_touch(touch_now[ch]),
        .o_noise(noise_now[ch]),
        .o_lid(lid_now[ch])
      );
    end
  endgenerate

  // status follows the latest sample; no stickiness is implied
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_touch <= 14'h0000;
      o_noise_spike <= 14'h0000;
      o_lid_status <= 14'h0000;
      o_lid_event <= 1'b0;
    end else if (i_en && i_sample_valid) begin
      o_touch <= touch_now;
      o_noise_spike <= noise_now;
      o_lid_status <= lid_now;
      // an all-zero pattern never flags
      o_lid_event <= (i_lid_pattern != 14'h0000) &&
                     ((lid_now & i_lid_pattern) == i_lid_pattern);
    end
  end

  // --------------------------------------------------
  // millisecond tick and slide speed
  // --------------------------------------------------
  logic [$clog2(MS_TICK_CYCLES)-1:0] tick_cnt;
  logic ms_tick;
  logic [6:0] win_ms;
  logic [2:0] new_count;
  logic [6:0] group_prev;
  logic [6:0] group_rise;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt <= '0;
      ms_tick <= 1'b0;
    end else if (i_en) begin
      ms_tick <= (tick_cnt == ($bits(tick_cnt))'(MS_TICK_CYCLES - 1));
      if (tick_cnt == ($bits(tick_cnt))'(MS_TICK_CYCLES - 1)) begin
        tick_cnt <= '0;
      end else begin
        tick_cnt <= tick_cnt + 1'b1;
      end
    end
  end

  assign group_rise = o_touch[13:7] & ~group_prev;

  // fixed windows, not a sliding one: cheaper, and within one window of truth
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      group_prev <= 7'h00;
      win_ms <= 7'h00;
      new_count <= 3'h0;
      o_speed_count <= 3'h0;
    end else if (i_en) begin
      group_prev <= o_touch[13:7];
      if (ms_tick && win_ms == 7'(SPEED_WINDOW_MS - 1)) begin
        win_ms <= 7'h00;
        o_speed_count <= new_count;
        new_count <= 3'(($countones(group_rise) > 0) ? 1 : 0);
      end else begin
        if (ms_tick) begin
          win_ms <= win_ms + 7'h01;
        end
        if (group_rise != 7'h00 && new_count != 3'h7) begin
          new_count <= new_count + 3'h1;
        end
      end
    end
  end

  // --------------------------------------------------
  // slide timing and interrupts
  // --------------------------------------------------
  slide_state_e state;
  logic [9:0] slide_ms;
  logic [9:0] win_limit;
  logic fast_seen;
  logic [3:0] rpt_cnt;
  logic [2:0] extra_left;
  logic [3:0] interval;
  logic [2:0] extra_count;
  logic [1:0] band;
  logic slider_on;

  assign slider_on = |o_touch[13:7];

  always_comb begin
    case (slide_window_code)
      2'b00: win_limit = 10'(`SLIDE_WIN0_MS);
      2'b01: win_limit = 10'(`SLIDE_WIN1_MS);
      2'b10: win_limit = 10'(`SLIDE_WIN2_MS);
      default: win_limit = 10'(`SLIDE_WIN3_MS);
    endcase
    if (slide_ms < (win_limit >> 1)) begin
      band = band_fast;
    end else if (slide_ms < win_limit - (win_limit >> 2)) begin
      band = band_mid;
    end else begin
      band = band_slow;
    end
  end

  slide_rate_decode u_rate (
    .i_speed(o_speed_count),
    .i_scale(speed_repeat_scale),
    .i_base_cycles(i_slider_base_repeat_rate),
    .i_max_int(max_extra),
    .i_band(band),
    .o_interval(interval),
    .o_extra(extra_count)
  );

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slide_ms <= 10'h000;
      fast_seen <= 1'b0;
    end else if (i_en) begin
      if (state == st_slide) begin
        if (ms_tick && slide_ms != 10'h3ff) begin
          slide_ms <= slide_ms + 10'h001;
        end
        if (o_speed_count >= 3'd2) begin
          fast_seen <= 1'b1;
        end
      end else begin
        slide_ms <= 10'h000;
        fast_seen <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= st_idle;
      rpt_cnt <= 4'h0;
      extra_left <= 3'h0;
      o_irq <= 1'b0;
    end else if (i_en) begin
      o_irq <= 1'b0;
      if (i_sample_valid) begin
        case (state)
          st_idle: begin
            if (slider_on) begin
              state <= st_slide;
              rpt_cnt <= 4'h1;
              o_irq <= 1'b1;
            end
          end
          st_slide: begin
            if (!slider_on) begin
              // slow or unaccelerated slides end quietly
              if (accel_extra_irq_enable && fast_seen &&
                  slide_ms <= win_limit && extra_count != 3'h0) begin
                extra_left <= extra_count;
                state <= st_extra;
              end else begin
                state <= st_idle;
              end
            end else if (rpt_cnt >= interval) begin
              rpt_cnt <= 4'h1;
              o_irq <= 1'b1;
            end else begin
              rpt_cnt <= rpt_cnt + 4'h1;
            end
          end
          st_extra: begin
            if (slider_on) begin
              extra_left <= 3'h0;
              state <= st_slide;
              rpt_cnt <= 4'h1;
              o_irq <= 1'b1;
            end else begin
              o_irq <= 1'b1;
              extra_left <= extra_left - 3'h1;
              if (extra_left == 3'h1) begin
                state <= st_idle;
              end
            end
          end
          default: state <= st_idle;
        endcase
      end
    end
  end
endmodule

// ===== pkg/touch_defines.svh
`ifndef TOUCH_DEFINES_SVH
`define TOUCH_DEFINES_SVH
// --------------------------------------------------
// register offsets
// --------------------------------------------------
`define OFS_NOISE_CH1_4 8'h38
`define OFS_NOISE_CH5_7_GRP 8'h39
`define OFS_LID_CH1_4 8'h3a
`define OFS_LID_CH5_8 8'h3b
`define OFS_LID_CH9_12 8'h3c
`define OFS_LID_CH13_14 8'h3d
`define OFS_SLIDE_CFG 8'h3e
// --------------------------------------------------
// reset values
// --------------------------------------------------
`define RST_NOISE 8'haa
`define RST_LID 8'haa
`define RST_LID_LAST 8'h0a
`define RST_SLIDE_CFG 8'hc5
// --------------------------------------------------
// field positions
// --------------------------------------------------
`define ACCEL_EN_BIT 7
`define MAX_INT_LSB 4
`define SLIDE_TIME_LSB 2
`define SCALE_LSB 0
`define LID_LAST_MASK 8'h0f
// --------------------------------------------------
// timing
// --------------------------------------------------
`define CLK_KHZ 20000
`define SPEED_WINDOW_MS 100
`define SLIDE_WIN0_MS 350
`define SLIDE_WIN1_MS 560
`define SLIDE_WIN2_MS 770
`define SLIDE_WIN3_MS 980
`define MEAS_CYCLE_MS 35
`define RPT_35_MS 35
`define RPT_70_MS 70
`define RPT_105_MS 105
`define RPT_140_MS 140
`define FIXED_SCALE_LIMIT_MS 105
`endif

// ===== pkg/touch_pkg.sv
package touch_pkg;
  typedef enum logic [1:0] {
    frac_6p25 = 2'b00,
    frac_12p5 = 2'b01,
    frac_25 = 2'b10,
    frac_50 = 2'b11
  } fraction_e;
  typedef enum logic [1:0] {
    band_fast = 2'b00,
    band_mid = 2'b01,
    band_slow = 2'b10
  } slide_band_e;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_slide = 2'b01,
    st_extra = 2'b10
  } slide_state_e;
endpackage

// ===== logic/channel_qualify.sv
`timescale 1ns/100ps
module channel_qualify
  import touch_pkg::*;
#(
  parameter int DELTA_W = 8
) (
  input wire logic [6:0] i_thresh,
  input wire logic [1:0] i_noise_frac,
  input wire logic [1:0] i_lid_frac,
  input wire logic [DELTA_W-1:0] i_delta,
  output logic o_touch,
  output logic o_noise,
  output logic o_lid
);
  logic [6:0] noise_thresh;
  logic [6:0] lid_thresh;

  function automatic logic [6:0] scale_thresh(
    input logic [6:0] th,
    input logic [1:0] code
  );
    logic [6:0] r;
    r = th;
    case (fraction_e'(code))
      frac_6p25: r = th >> 4;
      frac_12p5: r = th >> 3;
      frac_25: r = th >> 2;
      frac_50: r = th >> 1;
      default: r = th >> 2;
    endcase
    return r;
  endfunction

  always_comb begin
    noise_thresh = scale_thresh(i_thresh, i_noise_frac);
    lid_thresh = scale_thresh(i_thresh, i_lid_frac);
    o_touch = i_delta > DELTA_W'(i_thresh);
    o_noise = (i_delta > DELTA_W'(noise_thresh)) && !o_touch;
    o_lid = i_delta > DELTA_W'(lid_thresh);
  end
endmodule

// ===== logic/slide_rate_decode.sv
`timescale 1ns/100ps
`include "touch_defines.svh"
module slide_rate_decode
  import touch_pkg::*;
#(
  // extra interrupt count per limit code, 3 bits per code, code 0 lowest
  parameter logic [23:0] EXTRA_FAST = 24'hfac688,
  parameter logic [23:0] EXTRA_MID = 24'h6d2240,
  parameter logic [23:0] EXTRA_SLOW = 24'h249000
) (
  input wire logic [2:0] i_speed,
  input wire logic [1:0] i_scale,
  input wire logic [3:0] i_base_cycles,
  input wire logic [2:0] i_max_int,
  input wire logic [1:0] i_band,
  output logic [3:0] o_interval,
  output logic [2:0] o_extra
);
  localparam logic [3:0] C35 = 4'(`RPT_35_MS / `MEAS_CYCLE_MS);
  localparam logic [3:0] C70 = 4'(`RPT_70_MS / `MEAS_CYCLE_MS);
  localparam logic [3:0] C105 = 4'(`RPT_105_MS / `MEAS_CYCLE_MS);
  localparam logic [3:0] C140 = 4'(`RPT_140_MS / `MEAS_CYCLE_MS);
  localparam logic [3:0] CLIM = 4'(`FIXED_SCALE_LIMIT_MS / `MEAS_CYCLE_MS);

  logic [3:0] iv;

  // intervals are counted in measurement cycles, not milliseconds
  always_comb begin
    iv = C35;
    if (i_speed >= 3'd5) begin
      iv = C35;
    end else if (i_scale == 2'b11 && i_speed >= 3'd2 && i_base_cycles <= CLIM) begin
      case (i_speed)
        3'd2: iv = C140;
        3'd3: iv = C105;
        default: iv = C70;
      endcase
    end else begin
      case (i_speed)
        3'd4: iv = (i_scale == 2'b11) ? C70 : C35;
        3'd3: begin
          case (i_scale)
            2'b10: iv = C70;
            2'b11: iv = C105;
            default: iv = C35;
          endcase
        end
        3'd2: begin
          case (i_scale)
            2'b00: iv = C35;
            2'b01: iv = C70;
            2'b10: iv = C105;
            default: iv = C140;
          endcase
        end
        default: iv = i_base_cycles;
      endcase
    end
    o_interval = (iv == 4'h0) ? 4'h1 : iv;
  end

  // lookup stays a parameter until the counts are confirmed on silicon
  always_comb begin
    case (slide_band_e'(i_band))
      band_fast: o_extra = EXTRA_FAST[i_max_int*3 +: 3];
      band_mid: o_extra = EXTRA_MID[i_max_int*3 +: 3];
      default: o_extra = EXTRA_SLOW[i_max_int*3 +: 3];
    endcase
  end
endmodule

// ===== verification/touch_threshold_slider_accel_chk.sv
`timescale 1ns/100ps
module touch_threshold_slider_accel_chk (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_sample_valid,
  input wire logic [13:0] i_lid_pattern,
  input wire logic [13:0] o_touch,
  input wire logic [13:0] o_noise_spike,
  input wire logic [13:0] o_lid_status,
  input wire logic o_lid_event,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  logic smp;
  assign smp = i_en && i_sample_valid;
  // ------------------------------------------
  // register port and sample path
  // ------------------------------------------
  a_wr_rd_back: assert property (
    (i_en && i_reg_wr && i_reg_addr inside {[8'h38:8'h3c], 8'h3e})
    ##1 (i_en && i_reg_rd && i_reg_addr == $past(i_reg_addr))
    |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("read back differs");
  a_lid_last_mask: assert property (
    i_en && i_reg_rd && i_reg_addr == 8'h3d |=> o_reg_rdata[7:4] == 4'h0)
    else $error("unused lid bits read nonzero");
  a_spike_not_touch: assert property ((o_noise_spike & o_touch) == 14'h0)
    else $error("spike flagged on a touched channel");
  // lid threshold never exceeds the touch threshold
  a_touch_has_lid: assert property ((o_touch & ~o_lid_status) == 14'h0)
    else $error("touch without lid status");
  a_hold_samples: assert property (
    !smp |=> $stable(o_touch) && $stable(o_noise_spike) && $stable(o_lid_status))
    else $error("channel flags moved without a sample");
  a_lid_event_off: assert property (
    smp && i_lid_pattern == 14'h0 |=> !o_lid_event) else $error("event with empty pattern");
  a_event_status: assert property (o_lid_event |-> o_lid_status != 14'h0)
    else $error("event without lid status");
  a_irq_on_sample: assert property (o_irq |-> $past(smp))
    else $error("irq not tied to a measurement cycle");
endmodule
bind touch_threshold_slider_accel touch_threshold_slider_accel_chk chk_u (
  .i_clk_sys, .i_arst_n, .i_en, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
  .o_reg_rdata, .i_sample_valid, .i_lid_pattern, .o_touch, .o_noise_spike,
  .o_lid_status, .o_lid_event, .o_irq);

// ===== verification/host_model.sv
`timescale 1ns/100ps
module host_model (
  input wire logic i_clk_sys,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // a strobe still high from the last call costs one idle edge, so it is never set twice
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    if (o_wr) @(posedge i_clk_sys);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a);
    if (o_rd) @(posedge i_clk_sys);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
  endtask
endmodule

// ===== verification/tb_touch_threshold_slider_accel.sv
`timescale 1ns/100ps
module tb_touch_threshold_slider_accel;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_en = 1'b1;
  logic [48:0] btn_th = '0;
  logic [6:0] grp_th = 7'h40;
  logic [111:0] delta = '0;
  logic smp_v = 1'b0;
  logic [13:0] pat = '0;
  logic [3:0] base_rate = 4'h3;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, lev, irq;
  logic [13:0] touch, spike, lid;
  logic [2:0] spd;
  logic [7:0] regs [7] = '{8'haa, 8'haa, 8'haa, 8'haa, 8'haa, 8'h0a, 8'hc5};
  logic [7:0] cfgs [4] = '{8'hcc, 8'hac, 8'h7c, 8'hc0};
  int nx [4] = '{4, 2, 0, 0};
  int nk [4] = '{14, 14, 14, 400};
  logic [7:0] exp_reg [$];
  logic [42:0] exp_ch [$];
  int num_errors = 0, num_checks = 0, cycles = 0, irq_cnt = 0, c0;
  logic rd_d = 1'b0, sv_d1 = 1'b0, sv_d2 = 1'b0;
  always #25 i_clk_sys = ~i_clk_sys;
  host_model host_u (.i_clk_sys(i_clk_sys), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
    .o_rd(rd));
  touch_threshold_slider_accel #(.DELTA_W(8), .MS_TICK_CYCLES(4), .SPEED_WINDOW_MS(4)) dut_u (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_en(i_en), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_button_thresh(btn_th), .i_group_thresh(grp_th), .i_delta(delta),
    .i_sample_valid(smp_v), .i_lid_pattern(pat), .i_slider_base_repeat_rate(base_rate),
    .o_touch(touch), .o_noise_spike(spike), .o_lid_status(lid), .o_lid_event(lev),
    .o_speed_count(spd), .o_irq(irq));
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk8(logic [7:0] got, logic [7:0] e);
    num_checks++;
    if (got !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t byte got %h exp %h", $time, got, e);
    end
  endtask
  task automatic chk43(logic [42:0] got, logic [42:0] e);
    num_checks++;
    if (got !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t flags got %h exp %h", $time, got, e);
    end
  endtask
  // ------------------------------------------
  // expectations and drivers
  // ------------------------------------------
  function automatic logic [42:0] calc(logic [111:0] d, logic [13:0] p);
    logic [13:0] t, n, l;
    int th, nc, lc, dv;
    for (int i = 0; i < 14; i++) begin
      th = (i < 7) ? btn_th[7*i+:7] : grp_th;
      nc = (i < 4) ? regs[0][2*i+:2] : (i < 7) ? regs[1][2*i-8+:2] : regs[1][7:6];
      lc = regs[2+i/4][2*(i%4)+:2];
      dv = d[8*i+:8];
      t[i] = dv > th;
      n[i] = dv > (th >> (4 - nc)) && !t[i];
      l[i] = dv > (th >> (4 - lc));
    end
    return {t, n, l, p != 14'h0 && (p & l) == p};
  endfunction
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    host_u.reg_write(a, d);
    if (i_en && a >= 8'h38 && a <= 8'h3e) regs[a-8'h38] = (a == 8'h3d) ? d & 8'h0f : d;
  endtask
  task automatic rd_reg(logic [7:0] a);
    exp_reg.push_back((a >= 8'h38 && a <= 8'h3e) ? regs[a-8'h38] : 8'h00);
    host_u.reg_read(a);
  endtask
  task automatic sample(logic [111:0] d, logic [13:0] p);
    exp_ch.push_back(calc(d, p));
    delta <= d;
    pat <= p;
    smp_v <= 1'b1;
    @(posedge i_clk_sys);
    smp_v <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
  endtask
  function automatic logic [111:0] grp(int k);
    return 112'hff << (8 * (7 + k));
  endfunction
  // ------------------------------------------
  // monitors
  // ------------------------------------------
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 12000) begin
      num_errors++;
      finish_test();
    end
  end
  always @(posedge i_clk_sys) begin
    if (irq === 1'b1) irq_cnt++;
    if (rd_d) chk8(rdata, exp_reg.pop_front());
    if (sv_d2) chk43({touch, spike, lid, lev}, exp_ch.pop_front());
    rd_d <= i_en && rd;
    sv_d1 <= i_en && smp_v;
    sv_d2 <= sv_d1;
  end
  initial begin
    void'($urandom(32'h4a44ef66));
    repeat (20) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    @(posedge i_clk_sys);
    for (int a = 8'h37; a <= 8'h3f; a++) rd_reg(8'(a));
    i_en <= 1'b0;
    wr_reg(8'h3e, 8'h00);
    i_en <= 1'b1;
    rd_reg(8'h3e);
    for (int a = 8'h37; a <= 8'h3f; a++) begin
      wr_reg(8'(a), 8'($urandom));
      rd_reg(8'(a));
    end
    for (int s = 0; s < 64; s++) begin
      if (s % 8 == 0) begin
        btn_th <= 49'({$urandom, $urandom});
        grp_th <= 7'($urandom);
        for (int a = 0; a < 6; a++) wr_reg(8'(8'h38 + a), 8'($urandom));
      end
      sample(112'({$urandom, $urandom, $urandom, $urandom}),
        (s % 3 == 0) ? 14'h0 : (s % 3 == 1) ? 14'(1 << (s % 14)) : 14'($urandom));
    end
    // one slider sensor held: interrupts at the base interval
    wr_reg(8'h3e, 8'h05);
    for (int b = 2; b <= 3; b++) begin
      base_rate <= 4'(b);
      repeat (8) sample('0, 14'h0);
      repeat (4) sample(grp(0), 14'h0);
      c0 = irq_cnt;
      repeat (12) sample(grp(0), 14'h0);
      chk8(8'(irq_cnt - c0), 8'(12 / b));
    end
    // a new sensor every second sample gives speed two: interval follows the scale code
    for (int sc = 0; sc < 4; sc++) begin
      wr_reg(8'h3e, 8'(8'h04 + sc));
      repeat (8) sample('0, 14'h0);
      for (int k = 0; k < 10; k++) sample(grp(k / 2 % 7), 14'h0);
      c0 = irq_cnt;
      for (int k = 10; k < 22; k++) sample(grp(k / 2 % 7), 14'h0);
      chk8(8'(irq_cnt - c0), 8'(12 / (sc + 1)));
      chk8(8'(spd), 8'h02);
    end
    // fast slides capped by the limit, none when disabled or slower than the window
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h3e, cfgs[c]);
      repeat (8) sample('0, 14'h0);
      chk8(8'(spd), 8'h00);
      for (int k = 0; k < nk[c]; k++) sample(grp(k % 7), 14'h0);
      chk8(8'(spd), 8'h04);
      sample('0, 14'h0);
      c0 = irq_cnt;
      repeat (10) sample('0, 14'h0);
      chk8(8'(irq_cnt - c0), 8'(nx[c]));
    end
    // a second reset in mid-run brings every register back to its default
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    regs = '{8'haa, 8'haa, 8'haa, 8'haa, 8'haa, 8'h0a, 8'hc5};
    @(posedge i_clk_sys);
    for (int a = 8'h38; a <= 8'h3e; a++) rd_reg(8'(a));
    repeat (3) @(posedge i_clk_sys);
    finish_test();
  end
endmodule
